// ==== common/irq_bank_defs.svh ====
`ifndef IRQ_BANK_DEFS_SVH
`define IRQ_BANK_DEFS_SVH

// ----------------------------------------
// register word indices (byte address = 4 x index)
// ----------------------------------------
`define IDX_FLAGS_TWO 3'h0
`define IDX_FLAGS_THREE 3'h1
`define IDX_EN_ONE 3'h2
`define IDX_EN_TWO 3'h3
`define IDX_EN_THREE 3'h4
`define IDX_CTRL 3'h5
`define IDX_FLAGS_ONE 3'h6

// ----------------------------------------
// implemented and writable bit masks
// ----------------------------------------
`define MASK_FLAGS_ONE 8'h03
`define MASK_FLAGS_TWO 8'hcb
`define WMASK_FLAGS_THREE 8'hcf
`define MASK_EN_ONE 8'hff
`define MASK_EN_TWO 8'hcb
`define MASK_EN_THREE 8'hff
`define MASK_CTRL 8'h07
`define REG_RESET 8'h00
`define WORD_ZERO 32'h0000_0000

// ----------------------------------------
// bit positions
// ----------------------------------------
`define F1_TMR2 1
`define F1_TMR1 0
`define F2_OSC 7
`define F2_CMP 6
`define F2_BCL1 3
`define F2_TMR3 1
`define F2_CC2 0
`define F3_SSP2 7
`define F3_BCL2 6
`define F3_RX2 5
`define F3_TX2 4
`define F3_TMR4 3
`define F3_CC3 0
`define CTRL_GROUP 0
`define CTRL_PRIO 1
`define CTRL_GLOBAL 2

`endif

// ==== common/irq_bank_pkg.sv ====
package irq_bank_pkg;

   // capture/compare unit operating mode
   typedef enum logic [1:0] {
      CC_CAPTURE = 2'b00,
      CC_COMPARE = 2'b01,
      CC_PWM = 2'b10,
      CC_OFF = 2'b11
   } cc_mode_t;

   // bus answer sequencer
   typedef enum logic {
      BUS_IDLE = 1'b0,
      BUS_DONE = 1'b1
   } bus_state_t;

   typedef struct packed {
      logic [2:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } avmm_req_t;

   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } avmm_rsp_t;

   // one-cycle event strobes from peripherals
   typedef struct packed {
      logic osc_fail;
      logic comparator_change;
      logic bus_collision_one;
      logic timer3_overflow;
      logic sync_serial_two_done;
      logic bus_collision_two;
      logic timer4_match;
      logic timer2_match;
      logic timer1_overflow;
   } periph_event_t;

   typedef struct packed {
      cc_mode_t mode;
      logic capture;
      logic match;
   } cc_event_t;

   typedef struct packed {
      bus_state_t state;
      logic [7:0] flags_one;
      logic [7:0] flags_two;
      logic [7:0] flags_three;
      logic [7:0] en_one;
      logic [7:0] en_two;
      logic [7:0] en_three;
      logic [7:0] ctrl;
      logic [31:0] readdata;
   } bank_state_t;

endpackage

// ==== verif/periph_event_model.sv ====
`timescale 1ns/100ps

// ------
// peripheral side: event strobes and buffer levels
// ------
module periph_event_model
   import irq_bank_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   // commands from the bench
   input wire periph_event_t fire_i,
   input wire cc_event_t [3:0] cc_fire_i,
   input wire logic rx_arrive_i,
   input wire logic rx_take_i,
   input wire logic tx_put_i,
   input wire logic tx_drain_i,
   // toward the bank
   output periph_event_t events_o,
   output cc_event_t [3:0] capcomp_o,
   output logic rx_full_o,
   output logic tx_empty_o
);
   // strobes leave a flop one cycle after the command and last as many cycles as the command is held
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         events_o <= '0;
         capcomp_o <= '0;
      end else begin
         events_o <= fire_i;
         capcomp_o <= cc_fire_i;
      end
   end

   // buffer levels: receive side fills and is read, transmit side drains and is written
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rx_full_o <= 1'b0;
         tx_empty_o <= 1'b1; // nothing queued after reset
      end else begin
         rx_full_o <= (rx_full_o | rx_arrive_i) & ~rx_take_i;
         tx_empty_o <= (tx_empty_o | tx_drain_i) & ~tx_put_i;
      end
   end
endmodule // periph_event_model

// ==== verif/tb_peripheral_irq_flag_enable_bank.sv ====
`timescale 1ns/100ps
`include "irq_bank_defs.svh"

module tb_peripheral_irq_flag_enable_bank
   import irq_bank_pkg::*;
;
   // ------
   // stimulus and observation
   // ------
   logic sys_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic [2:0] avs_address_i = 3'h0;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0000_0000;
   logic [3:0] avs_byteenable_i = 4'h0;
   periph_event_t fire = '0;
   cc_event_t [3:0] cc_fire = '0;
   logic [3:0] lvl_cmd = 4'h0;
   periph_event_t events;
   cc_event_t [3:0] capcomp;
   cc_event_t [3:0] cc;
   logic rx_full;
   logic tx_empty;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic periph_pending_o;
   logic periph_irq_o;
   logic priority_mode_bit_o;
   logic global_irq_enable_o;
   logic [31:0] rd;
   logic [7:0] ctrl;
   logic [2:0] cidx;
   logic [7:0] cbit;
   int err_count = 0;
   int tests_run = 0;
   // register index and bit of each event field, osc_fail first
   logic [2:0] ev_idx [9] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h6, 3'h6};
   logic [7:0] ev_bit [9] = '{8'h80, 8'h40, 8'h08, 8'h02, 8'h80, 8'h40, 8'h08, 8'h02, 8'h01};

   always #5 sys_clk_i = ~sys_clk_i;

   // ------
   // design and peripheral model
   // ------
   peripheral_irq_flag_enable_bank u_dut (
      .sys_clk_i, .reset_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
      .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
      .events_i(events), .capcomp_i(capcomp),
      .async_two_rx_full_i(rx_full), .async_two_tx_empty_i(tx_empty),
      .periph_pending_o, .periph_irq_o, .priority_mode_bit_o, .global_irq_enable_o
   );
   periph_event_model u_periph (
      .sys_clk_i, .reset_n_i, .fire_i(fire), .cc_fire_i(cc_fire),
      .rx_arrive_i(lvl_cmd[3]), .rx_take_i(lvl_cmd[2]), .tx_put_i(lvl_cmd[1]),
      .tx_drain_i(lvl_cmd[0]), .events_o(events), .capcomp_o(capcomp),
      .rx_full_o(rx_full), .tx_empty_o(tx_empty)
   );

   // ------
   // tasks
   // ------
   task automatic tally_and_finish();
      if (err_count == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   // one bus cycle, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [2:0] idx, input logic [7:0] data,
                      input logic [3:0] be);
      int n;
      @(posedge sys_clk_i);
      avs_address_i <= idx;
      avs_write_i <= wr;
      avs_read_i <= ~wr;
      avs_writedata_i <= {24'h00_0000, data};
      avs_byteenable_i <= be;
      n = 0;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 16);
      if (avs_waitrequest_o !== 1'b0) begin
         err_count++;
         tally_and_finish();
      end else begin
         rd = avs_readdata_o;
         avs_write_i <= 1'b0;
         avs_read_i <= 1'b0;
      end
   endtask

   task automatic wr_reg(input logic [2:0] idx, input logic [7:0] data);
      bus(1'b1, idx, data, 4'h1);
   endtask

   task automatic expect_reg(input logic [2:0] idx, input logic [7:0] exp, input string what);
      bus(1'b0, idx, 8'h00, 4'hf);
      check(what, rd, {24'h00_0000, exp});
   endtask

   // one-cycle command toward the peripheral model
   task automatic pulse(input periph_event_t ev, input cc_event_t [3:0] c);
      @(posedge sys_clk_i);
      fire <= ev;
      cc_fire <= c;
      @(posedge sys_clk_i);
      fire <= '0;
      cc_fire <= '0;
   endtask

   task automatic levels(input logic [3:0] cmd);
      @(posedge sys_clk_i);
      lvl_cmd <= cmd;
      @(posedge sys_clk_i);
      lvl_cmd <= 4'h0;
   endtask

   // ------
   // main sequence
   // ------
   initial begin
      repeat (6) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      // reset values, transmit buffer empty, unmapped index reads zero
      for (int i = 0; i < 8; i++) begin
         expect_reg(3'(i), (i == 1) ? 8'h10 : 8'h00, "reset value");
      end
      // enable registers: lane 0 off ignored, unimplemented bits read zero
      for (int i = 0; i < 3; i++) begin
         wr_reg(3'(i + 2), 8'hff);
         bus(1'b1, 3'(i + 2), 8'h00, 4'he);
         expect_reg(3'(i + 2), (i == 1) ? 8'hcb : 8'hff, "enable bits");
         wr_reg(3'(i + 2), 8'h00);
         expect_reg(3'(i + 2), 8'h00, "enable cleared");
      end
      // every event sets its flag with all enables off, software clears it
      levels(4'b0010);
      for (int i = 0; i < 9; i++) begin
         pulse(periph_event_t'(9'h100 >> i), '0);
         expect_reg(ev_idx[i], ev_bit[i], "event flag");
         wr_reg(ev_idx[i], 8'h00);
         expect_reg(ev_idx[i], 8'h00, "cleared flag");
      end
      // capture/compare units in all four modes
      for (int u = 0; u < 4; u++) begin
         cidx = (u == 0) ? 3'h0 : 3'h1;
         cbit = (u == 0) ? 8'h01 : 8'(8'h01 << (u - 1));
         for (int m = 0; m < 4; m++) begin
            cc = '0;
            cc[u] = '{cc_mode_t'(m), m != 1, m != 0};
            pulse('0, cc);
            expect_reg(cidx, (m < 2) ? cbit : 8'h00, "unit flag");
            wr_reg(cidx, 8'h00);
         end
      end
      // unimplemented flag bits and read-only buffer status bits
      wr_reg(3'h0, 8'hff);
      expect_reg(3'h0, 8'hcb, "flags two mask");
      wr_reg(3'h0, 8'h00);
      levels(4'b1000);
      wr_reg(3'h1, 8'hff);
      expect_reg(3'h1, 8'hef, "flags three set");
      wr_reg(3'h1, 8'h00);
      expect_reg(3'h1, 8'h20, "receive still full");
      levels(4'b0100);
      expect_reg(3'h1, 8'h00, "receive read");
      levels(4'b0001);
      expect_reg(3'h1, 8'h10, "transmit empty");
      // request gating over every control setting
      pulse(periph_event_t'(9'h001), '0);
      wr_reg(3'h2, 8'h01);
      for (int c = 0; c < 8; c++) begin
         ctrl = 8'(c);
         wr_reg(3'h5, ctrl);
         @(negedge sys_clk_i);
         check("pending", {31'h0, periph_pending_o}, 32'h1);
         check("irq", {31'h0, periph_irq_o}, {31'h0, ctrl[0] & ctrl[2]});
         check("mode bits", {30'h0, priority_mode_bit_o, global_irq_enable_o},
               {30'h0, ctrl[1], ctrl[2]});
      end
      // other enables do not unmask the pending flag
      wr_reg(3'h2, 8'hfe);
      @(negedge sys_clk_i);
      check("masked", {30'h0, periph_pending_o, periph_irq_o}, 32'h0);
      // a fresh event on an enabled source raises the request
      pulse(periph_event_t'(9'h002), '0);
      repeat (2) @(negedge sys_clk_i);
      check("irq raised", {31'h0, periph_irq_o}, 32'h1);
      // reset in mid-run clears the outputs, control, enables one and flags one
      wr_reg(3'h2, 8'h01);
      @(posedge sys_clk_i);
      reset_n_i <= 1'b0;
      @(negedge sys_clk_i);
      check("outputs in reset", {29'h0, periph_irq_o, periph_pending_o,
            global_irq_enable_o}, 32'h0);
      repeat (2) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      expect_reg(3'h5, 8'h00, "control after reset");
      expect_reg(3'h2, 8'h00, "enables after reset");
      expect_reg(3'h6, 8'h00, "flags after reset");
      tally_and_finish();
   end
endmodule // tb_peripheral_irq_flag_enable_bank

// ==== verilog/peripheral_irq_flag_enable_bank.sv ====
// Added by the designer: the register offsets and the Avalon-MM register port.
`timescale 1ns/100ps
`include "irq_bank_defs.svh"

module peripheral_irq_flag_enable_bank
   import irq_bank_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   // avalon-mm slave
   input wire logic [2:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // peripheral events
   input wire periph_event_t events_i,
   input wire cc_event_t [3:0] capcomp_i,
   input wire logic async_two_rx_full_i,
   input wire logic async_two_tx_empty_i,
   // toward the core
   output logic periph_pending_o,
   output logic periph_irq_o,
   output logic priority_mode_bit_o,
   output logic global_irq_enable_o
);

   // ----------------------------------------
   // reset release
   // ----------------------------------------
   logic [1:0] rst_sync_reg;
   logic rst_n;

   // two-stage release of the async reset
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_sync_reg <= 2'b00;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // byte write merge limited to writable bits
   function automatic logic [7:0] merge(
      input logic [7:0] old,
      input logic [7:0] data,
      input logic [7:0] mask
   );
      merge = (old & ~mask) | (data & mask);
   endfunction

   // unit flag source by mode
   function automatic logic cc_hit(input cc_event_t e);
      cc_hit = ((e.mode == CC_CAPTURE) && e.capture)
         || ((e.mode == CC_COMPARE) && e.match);
   endfunction

   avmm_req_t req;
   avmm_rsp_t rsp;
   bank_state_t state_reg;
   bank_state_t state_next;
   logic [3:0] cc_set;
   logic wr_go;
   logic [7:0] wbyte;
   logic [7:0] f2_set;
   logic [7:0] f3_set;
   logic [7:0] f1_set;
   logic pending;
   logic group_en;
   logic global_en;

   assign req = '{avs_address_i, avs_read_i, avs_write_i,
      avs_writedata_i, avs_byteenable_i};

   // capture/compare sources, unit 2 at index 0
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_cc
         assign cc_set[gi] = cc_hit(capcomp_i[gi]);
      end
   endgenerate

   // ----------------------------------------
   // event set vectors
   // ----------------------------------------
   // sets ignore enables so software may poll
   always_comb begin
      f1_set = `REG_RESET;
      f1_set[`F1_TMR2] = events_i.timer2_match;
      f1_set[`F1_TMR1] = events_i.timer1_overflow;
      f2_set = `REG_RESET;
      f2_set[`F2_OSC] = events_i.osc_fail;
      f2_set[`F2_CMP] = events_i.comparator_change;
      f2_set[`F2_BCL1] = events_i.bus_collision_one;
      f2_set[`F2_TMR3] = events_i.timer3_overflow;
      f2_set[`F2_CC2] = cc_set[0];
      f3_set = `REG_RESET;
      f3_set[`F3_SSP2] = events_i.sync_serial_two_done;
      f3_set[`F3_BCL2] = events_i.bus_collision_two;
      f3_set[`F3_TMR4] = events_i.timer4_match;
      f3_set[`F3_CC3 +: 3] = cc_set[3:1];
   end

   // a write lands at the edge that ends the wait
   assign wr_go = req.write && (state_reg.state == BUS_DONE)
      && req.byteenable[0];
   assign wbyte = req.writedata[7:0];

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      state_next = state_reg;
      // bus sequencer and read capture
      case (state_reg.state)
         BUS_IDLE: begin
            if (req.read || req.write) begin
               state_next.state = BUS_DONE;
            end
            if (req.read) begin
               state_next.readdata = `WORD_ZERO;
               if (req.address == `IDX_FLAGS_TWO) begin
                  state_next.readdata[7:0] = state_reg.flags_two;
               end else if (req.address == `IDX_FLAGS_THREE) begin
                  state_next.readdata[7:0] = state_reg.flags_three;
               end else if (req.address == `IDX_EN_ONE) begin
                  state_next.readdata[7:0] = state_reg.en_one;
               end else if (req.address == `IDX_EN_TWO) begin
                  state_next.readdata[7:0] = state_reg.en_two;
               end else if (req.address == `IDX_EN_THREE) begin
                  state_next.readdata[7:0] = state_reg.en_three;
               end else if (req.address == `IDX_CTRL) begin
                  state_next.readdata[7:0] = state_reg.ctrl;
               end else if (req.address == `IDX_FLAGS_ONE) begin
                  state_next.readdata[7:0] = state_reg.flags_one;
               end
            end
         end
         BUS_DONE: begin
            state_next.state = BUS_IDLE;
         end
         default: begin
            state_next.state = BUS_IDLE;
         end
      endcase
      // software writes; unmapped addresses ignored
      if (wr_go) begin
         if (req.address == `IDX_FLAGS_TWO) begin
            state_next.flags_two = merge(state_reg.flags_two, wbyte,
               `MASK_FLAGS_TWO);
         end else if (req.address == `IDX_FLAGS_THREE) begin
            state_next.flags_three = merge(state_reg.flags_three,
               wbyte, `WMASK_FLAGS_THREE);
         end else if (req.address == `IDX_EN_ONE) begin
            state_next.en_one = merge(state_reg.en_one, wbyte,
               `MASK_EN_ONE);
         end else if (req.address == `IDX_EN_TWO) begin
            state_next.en_two = merge(state_reg.en_two, wbyte,
               `MASK_EN_TWO);
         end else if (req.address == `IDX_EN_THREE) begin
            state_next.en_three = merge(state_reg.en_three, wbyte,
               `MASK_EN_THREE);
         end else if (req.address == `IDX_CTRL) begin
            state_next.ctrl = merge(state_reg.ctrl, wbyte,
               `MASK_CTRL);
         end else if (req.address == `IDX_FLAGS_ONE) begin
            state_next.flags_one = merge(state_reg.flags_one, wbyte,
               `MASK_FLAGS_ONE);
         end
      end
      // hardware sets win over a clearing write
      state_next.flags_one = state_next.flags_one | f1_set;
      state_next.flags_two = state_next.flags_two | f2_set;
      state_next.flags_three = state_next.flags_three | f3_set;
      // buffer status bits follow the serial port
      state_next.flags_three[`F3_RX2] = async_two_rx_full_i;
      state_next.flags_three[`F3_TX2] = async_two_tx_empty_i;
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   // all flags and enables clear at reset
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------
   // request toward the core
   // ----------------------------------------
   // flags meet enables, then group and global gates
   assign pending = |(state_reg.flags_one & state_reg.en_one)
      || |(state_reg.flags_two & state_reg.en_two)
      || |(state_reg.flags_three & state_reg.en_three);
   assign group_en = state_reg.ctrl[`CTRL_GROUP];
   assign global_en = state_reg.ctrl[`CTRL_GLOBAL];
   assign periph_pending_o = pending;
   assign periph_irq_o = pending && group_en && global_en;
   assign priority_mode_bit_o = state_reg.ctrl[`CTRL_PRIO];
   assign global_irq_enable_o = global_en;

   // bus answer
   assign rsp.readdata = state_reg.readdata;
   assign rsp.waitrequest = (req.read || req.write)
      && (state_reg.state != BUS_DONE);
   assign avs_readdata_o = rsp.readdata;
   assign avs_waitrequest_o = rsp.waitrequest;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n);

   logic wr_f1;
   logic wr_f2;
   logic wr_f3;
   assign wr_f1 = wr_go && (req.address == `IDX_FLAGS_ONE);
   assign wr_f2 = wr_go && (req.address == `IDX_FLAGS_TWO);
   assign wr_f3 = wr_go && (req.address == `IDX_FLAGS_THREE);

   // flag set and hold checks
   osc_fail_a: assert property (
      events_i.osc_fail |=> state_reg.flags_two[`F2_OSC])
      else $error("osc fail flag not set");
   cmp_change_a: assert property (
      events_i.comparator_change |=> state_reg.flags_two[`F2_CMP])
      else $error("comparator flag not set");
   bcl_one_a: assert property (
      events_i.bus_collision_one |=> state_reg.flags_two[`F2_BCL1])
      else $error("collision one flag not set");
   tmr3_ovf_a: assert property (
      events_i.timer3_overflow |=> state_reg.flags_two[`F2_TMR3])
      else $error("timer3 flag not set");
   unimpl_zero_a: assert property (
      wr_go |=> (state_reg.flags_two & ~`MASK_FLAGS_TWO) == 8'h00
      && (state_reg.en_two & ~`MASK_EN_TWO) == 8'h00)
      else $error("unimplemented bit set");
   cc_capture_a: assert property (
      capcomp_i[0].mode == CC_CAPTURE && capcomp_i[0].capture
      |=> state_reg.flags_two[`F2_CC2])
      else $error("capture flag not set");
   cc_pwm_quiet_a: assert property (
      capcomp_i[1].mode == CC_PWM && !state_reg.flags_three[`F3_CC3]
      && !wr_f3 |=> !state_reg.flags_three[`F3_CC3])
      else $error("flag set in pwm mode");
   cc_compare_a: assert property (
      capcomp_i[3].mode == CC_COMPARE && capcomp_i[3].match
      |=> state_reg.flags_three[`F3_CC3 + 2])
      else $error("compare flag not set");
   ssp_two_a: assert property (
      events_i.sync_serial_two_done |=> state_reg.flags_three[`F3_SSP2]
      ##1 (state_reg.flags_three[`F3_SSP2] || $past(wr_f3)))
      else $error("serial two flag not held");
   bcl_two_a: assert property (
      events_i.bus_collision_two |=> state_reg.flags_three[`F3_BCL2]
      ##1 (state_reg.flags_three[`F3_BCL2] || $past(wr_f3)))
      else $error("collision two flag not held");
   // the status bits only follow once the state register has left reset
   rx_mirror_a: assert property (
      $past(rst_n) |-> state_reg.flags_three[`F3_RX2] == $past(async_two_rx_full_i))
      else $error("rx flag not mirrored");
   tx_mirror_a: assert property (
      $past(rst_n) |-> state_reg.flags_three[`F3_TX2] == $past(async_two_tx_empty_i))
      else $error("tx flag not mirrored");
   osc_hold_a: assert property (
      state_reg.flags_two[`F2_OSC] && !wr_f2 |=> state_reg.flags_two[`F2_OSC])
      else $error("osc fail flag dropped");
   cc_off_quiet_a: assert property (
      capcomp_i[2].mode == CC_OFF && !state_reg.flags_three[`F3_CC3 + 1]
      && !wr_f3 |=> !state_reg.flags_three[`F3_CC3 + 1])
      else $error("flag set in off mode");
   tmr4_hold_a: assert property (
      state_reg.flags_three[`F3_TMR4] && !wr_f3
      |=> state_reg.flags_three[`F3_TMR4])
      else $error("timer4 flag dropped");
   tmr4_match_a: assert property (
      events_i.timer4_match |=> state_reg.flags_three[`F3_TMR4])
      else $error("timer4 flag not set");
   tmr2_match_a: assert property (
      events_i.timer2_match |=> state_reg.flags_one[`F1_TMR2])
      else $error("timer2 flag not set");
   tmr1_hold_a: assert property (
      state_reg.flags_one[`F1_TMR1] && !wr_f1
      |=> state_reg.flags_one[`F1_TMR1])
      else $error("timer1 flag dropped");

   // enable, gate and reset checks
   global_gate_a: assert property (
      !global_en |-> !periph_irq_o)
      else $error("request without global enable");
   group_gate_a: assert property (
      !priority_mode_bit_o && !group_en |-> !periph_irq_o)
      else $error("request without group enable");
   en_one_wr_a: assert property (
      wr_go && req.address == `IDX_EN_ONE
      |=> state_reg.en_one == $past(wbyte))
      else $error("enables one not written");
   en_two_wr_a: assert property (
      wr_go && req.address == `IDX_EN_TWO
      |=> state_reg.en_two == ($past(wbyte) & `MASK_EN_TWO))
      else $error("enables two not written");
   en_three_wr_a: assert property (
      wr_go && req.address == `IDX_EN_THREE
      |=> state_reg.en_three == $past(wbyte))
      else $error("enables three not written");
   reset_clear_a: assert property (
      $rose(rst_n) |-> state_reg.flags_two == 8'h00
      && state_reg.en_one == 8'h00 && !periph_irq_o)
      else $error("bank not clear after reset");
   poll_set_a: assert property (
      events_i.timer1_overflow && !global_en
      |=> state_reg.flags_one[`F1_TMR1])
      else $error("flag gated by enable");
   low_prio_a: assert property (
      priority_mode_bit_o && group_en && global_en && pending
      |-> periph_irq_o)
      else $error("low priority request lost");
   request_a: assert property (
      events_i.timer2_match && state_reg.en_one[`F1_TMR2]
      && group_en && global_en && !wr_go |=> periph_irq_o)
      else $error("request not raised");

   // bus handshake checks
   bus_answer_a: assert property (
      (avs_read_i || avs_write_i) |-> ##[0:1] !avs_waitrequest_o)
      else $error("bus answer late");
   wait_first_a: assert property (
      (avs_read_i || avs_write_i) && state_reg.state == BUS_IDLE |-> avs_waitrequest_o)
      else $error("request answered without wait");
   rd_upper_a: assert property (
      avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h00_0000)
      else $error("read data upper bits set");
   be_lane_a: assert property (
      avs_write_i && !avs_waitrequest_o && !avs_byteenable_i[0]
      |=> $stable(state_reg.en_one))
      else $error("write without lane zero landed");

   rd_cov_c: cover property (avs_read_i && !avs_waitrequest_o);
   clr_race_c: cover property (wr_f2 && events_i.osc_fail);
   irq_cov_c: cover property (periph_irq_o);
   cc_cov_c: cover property (cc_set[2]);
   prio_irq_c: cover property (priority_mode_bit_o && periph_irq_o);

endmodule // peripheral_irq_flag_enable_bank
